/* File: rtl/hts_pkg.sv */
/*
 * Shared constants, types and helpers for the humidity/temperature
 * sensor command unit and the controller that drives it.
 * Assumes a single 125 MHz system clock on each side.
 */
package hts_pkg;

  // ***************************************************
  // Link addressing and command codes
  // ***************************************************
  // Target address value is arbitrary
  localparam logic [6:0] TARGET_ADDR = 7'h45;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [7:0] GEN_RESET_BYTE = 8'h06;
  localparam logic [7:0] CMD_MEAS_HIGH = 8'hFD;
  localparam logic [7:0] CMD_MEAS_MED = 8'hF6;
  localparam logic [7:0] CMD_MEAS_LOW = 8'hE0;
  localparam logic [7:0] CMD_SERIAL = 8'h89;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h94;
  localparam logic [7:0] CMD_HEAT_LONG_HI = 8'h39;
  localparam logic [7:0] CMD_HEAT_LONG_MID = 8'h2F;
  localparam logic [7:0] CMD_HEAT_LONG_LO = 8'h1E;
  localparam logic [7:0] CMD_HEAT_SHORT_HI = 8'h32;
  localparam logic [7:0] CMD_HEAT_SHORT_MID = 8'h24;
  localparam logic [7:0] CMD_HEAT_SHORT_LO = 8'h15;
  localparam logic [1:0] PWR_LO = 2'h1;
  localparam logic [1:0] PWR_MID = 2'h2;
  localparam logic [1:0] PWR_HI = 2'h3;

  // ***************************************************
  // Checksum
  // ***************************************************
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_XOROUT = 8'h00;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_NS = 8;
  localparam int MEAS_LOW_NS = 1_600_000;
  localparam int MEAS_MED_NS = 4_500_000;
  localparam int MEAS_HIGH_NS = 8_300_000;
  localparam int RESET_NS = 1_000_000;
  localparam int HEAT_LONG_NS = 1_000_000_000;
  localparam int HEAT_SHORT_NS = 100_000_000;
  // Longest times round down
  localparam int MEAS_LOW_CYC = MEAS_LOW_NS / CLK_NS;
  localparam int MEAS_MED_CYC = MEAS_MED_NS / CLK_NS;
  localparam int MEAS_HIGH_CYC = MEAS_HIGH_NS / CLK_NS;
  localparam int RESET_CYC = RESET_NS / CLK_NS;
  // Heating phase leaves room for the closing measurement
  localparam int HEAT_LONG_CYC = (HEAT_LONG_NS - MEAS_HIGH_NS) / CLK_NS;
  localparam int HEAT_SHORT_CYC = (HEAT_SHORT_NS - MEAS_HIGH_NS) / CLK_NS;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);

  // ***************************************************
  // State types
  // ***************************************************
  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_RX = 3'b001,
    LK_RX_ACK = 3'b010,
    LK_TX = 3'b011,
    LK_TX_ACK = 3'b100,
    LK_WAIT = 3'b101
  } link_st_t;

  typedef enum logic [1:0] {
    EN_IDLE = 2'b00,
    EN_MEAS = 2'b01,
    EN_HEAT = 2'b10,
    EN_RESET = 2'b11
  } eng_st_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BIT = 2'b10,
    HS_STOP = 2'b11
  } host_st_t;

  // ***************************************************
  // Helpers
  // ***************************************************
  function automatic logic [7:0] crc8_word(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c ^ CRC_XOROUT;
  endfunction

  function automatic logic [47:0] pack_words(input logic [15:0] a,
                                             input logic [15:0] b);
    return {a, crc8_word(a), b, crc8_word(b)};
  endfunction

endpackage

/* File: rtl/i2c_link_if.sv */
/*
 * Two-wire link between controller and sensor.
 * Both lines are open drain with an implied pull-up; the wired
 * level is resolved here from the output enables.
 */
`timescale 1ns/1ns
`default_nettype none

interface i2c_link_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) ||
                 (dev_sda_oe && !dev_sda_o));

  modport device (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

`default_nettype wire

/* File: rtl/hts_sensor_dev.sv */
/*
 * Sensor end: two-wire target that decodes commands, times
 * measurements and heater pulses, and returns checked words.
 * Assumes the link pins are asynchronous to sys_clk and that the
 * analog front end presents temp_in and hum_in as steady words.
 */
`timescale 1ns/1ns
`default_nettype none

module hts_sensor_dev
  import hts_pkg::*;
#(
  parameter int MEAS_LOW_CNT = MEAS_LOW_CYC,
  parameter int MEAS_MED_CNT = MEAS_MED_CYC,
  parameter int MEAS_HIGH_CNT = MEAS_HIGH_CYC,
  parameter int RESET_CNT = RESET_CYC,
  parameter int HEAT_LONG_CNT = HEAT_LONG_CYC,
  parameter int HEAT_SHORT_CNT = HEAT_SHORT_CYC,
  // Serial number value is arbitrary
  parameter logic [31:0] SERIAL_NUM = 32'h1234ABCD
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  i2c_link_if.device link,
  input wire logic [15:0] temp_in,
  input wire logic [15:0] hum_in,
  output logic heater_on,
  output logic [1:0] heater_power,
  output logic busy,
  output logic meas_done
);

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic [2:0] s_scl;
    logic [2:0] s_sda;
    logic scl_f;
    logic sda_f;
    link_st_t ls;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    logic is_hdr;
    logic gcall;
    logic rd;
    logic ack;
    logic [47:0] tx;
    logic sda_oe;
    eng_st_t es;
    logic [31:0] cnt;
    logic heater;
    logic [1:0] pwr;
    logic res_valid;
    logic [47:0] res;
    logic done;
  } dev_state_t;

  dev_state_t r_reg;
  dev_state_t r_next;
  logic scl_stable;
  logic sda_stable;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic eng_busy;

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.s_scl = {r_reg.s_scl[1:0], link.scl};
    r_next.s_sda = {r_reg.s_sda[1:0], link.sda};
    // Second and third stages must agree before a change counts
    scl_stable = (r_reg.s_scl[1] == r_reg.s_scl[2]);
    sda_stable = (r_reg.s_sda[1] == r_reg.s_sda[2]);
    if (scl_stable) begin
      r_next.scl_f = r_reg.s_scl[2];
    end
    if (sda_stable) begin
      r_next.sda_f = r_reg.s_sda[2];
    end
    scl_rise = scl_stable && r_reg.s_scl[2] && !r_reg.scl_f;
    scl_fall = scl_stable && !r_reg.s_scl[2] && r_reg.scl_f;
    start_cond = r_reg.scl_f && !scl_fall && sda_stable &&
                 !r_reg.s_sda[2] && r_reg.sda_f;
    stop_cond = r_reg.scl_f && !scl_fall && sda_stable &&
                r_reg.s_sda[2] && !r_reg.sda_f;
    eng_busy = (r_reg.es != EN_IDLE);

    // *************************************************
    // Measurement and heater engine
    // *************************************************
    if (eng_busy) begin
      if (r_reg.cnt > 32'd1) begin
        r_next.cnt = r_reg.cnt - 32'd1;
      end else begin
        case (r_reg.es)
          EN_HEAT: begin
            // Closing measurement with heater still on
            r_next.es = EN_MEAS;
            r_next.cnt = 32'(MEAS_HIGH_CNT);
          end
          EN_MEAS: begin
            r_next.es = EN_IDLE;
            r_next.heater = 1'b0;
            r_next.pwr = 2'h0;
            r_next.res = pack_words(temp_in, hum_in);
            r_next.res_valid = 1'b1;
            r_next.done = 1'b1;
          end
          default: begin
            r_next.es = EN_IDLE;
          end
        endcase
      end
    end

    // *************************************************
    // Link bit engine
    // *************************************************
    if (scl_rise) begin
      case (r_reg.ls)
        LK_RX: begin
          r_next.sh = {r_reg.sh[6:0], r_reg.s_sda[2]};
          r_next.bit_cnt = r_reg.bit_cnt + 4'd1;
        end
        LK_TX_ACK: begin
          // Controller NACK ends the read
          if (r_reg.s_sda[2]) begin
            r_next.ls = LK_WAIT;
          end
        end
        default: begin
        end
      endcase
    end

    if (scl_fall) begin
      case (r_reg.ls)
        LK_RX: begin
          if (r_reg.bit_cnt == 4'd8) begin
            r_next.ls = LK_RX_ACK;
            r_next.ack = 1'b0;
            if (r_reg.is_hdr) begin
              r_next.rd = r_reg.sh[0];
              if (r_reg.sh[7:1] == TARGET_ADDR) begin
                if (!r_reg.sh[0]) begin
                  r_next.ack = 1'b1;
                end else if (!eng_busy && r_reg.res_valid) begin
                  r_next.ack = 1'b1;
                  r_next.tx = r_reg.res;
                  r_next.res_valid = 1'b0;
                end
              end else if (r_reg.sh == {GEN_CALL_ADDR, 1'b0}) begin
                r_next.ack = 1'b1;
                r_next.gcall = 1'b1;
              end
            end else if (r_reg.gcall) begin
              r_next.ack = (r_reg.sh == GEN_RESET_BYTE);
            end else if (r_reg.sh == CMD_SOFT_RESET) begin
              r_next.ack = 1'b1;
            end else if (!eng_busy) begin
              r_next.ack = 1'b1;
              case (r_reg.sh)
                CMD_MEAS_HIGH: begin
                  r_next.es = EN_MEAS;
                  r_next.cnt = 32'(MEAS_HIGH_CNT);
                end
                CMD_MEAS_MED: begin
                  r_next.es = EN_MEAS;
                  r_next.cnt = 32'(MEAS_MED_CNT);
                end
                CMD_MEAS_LOW: begin
                  r_next.es = EN_MEAS;
                  r_next.cnt = 32'(MEAS_LOW_CNT);
                end
                CMD_SERIAL: begin
                  r_next.res = pack_words(SERIAL_NUM[31:16],
                                          SERIAL_NUM[15:0]);
                  r_next.res_valid = 1'b1;
                end
                CMD_HEAT_LONG_HI, CMD_HEAT_LONG_MID,
                CMD_HEAT_LONG_LO: begin
                  r_next.es = EN_HEAT;
                  r_next.cnt = 32'(HEAT_LONG_CNT);
                  r_next.heater = 1'b1;
                end
                CMD_HEAT_SHORT_HI, CMD_HEAT_SHORT_MID,
                CMD_HEAT_SHORT_LO: begin
                  r_next.es = EN_HEAT;
                  r_next.cnt = 32'(HEAT_SHORT_CNT);
                  r_next.heater = 1'b1;
                end
                default: begin
                  r_next.ack = 1'b0;
                end
              endcase
              if (r_next.es != EN_IDLE) begin
                r_next.res_valid = 1'b0;
              end
              case (r_reg.sh)
                CMD_HEAT_LONG_HI, CMD_HEAT_SHORT_HI: begin
                  r_next.pwr = PWR_HI;
                end
                CMD_HEAT_LONG_MID, CMD_HEAT_SHORT_MID: begin
                  r_next.pwr = PWR_MID;
                end
                CMD_HEAT_LONG_LO, CMD_HEAT_SHORT_LO: begin
                  r_next.pwr = PWR_LO;
                end
                default: begin
                end
              endcase
            end
            // Reset aborts any work and drops the result
            if (!r_reg.is_hdr && r_next.ack &&
                (r_reg.gcall || r_reg.sh == CMD_SOFT_RESET)) begin
              r_next.es = EN_RESET;
              r_next.cnt = 32'(RESET_CNT);
              r_next.heater = 1'b0;
              r_next.pwr = 2'h0;
              r_next.res_valid = 1'b0;
            end
            r_next.sda_oe = r_next.ack;
          end
        end
        LK_RX_ACK: begin
          r_next.is_hdr = 1'b0;
          r_next.bit_cnt = 4'd0;
          r_next.sda_oe = 1'b0;
          if (!r_reg.ack) begin
            r_next.ls = LK_WAIT;
          end else if (r_reg.is_hdr && r_reg.rd) begin
            r_next.ls = LK_TX;
            r_next.sda_oe = !r_reg.tx[47];
            r_next.tx = {r_reg.tx[46:0], 1'b1};
            r_next.bit_cnt = 4'd1;
          end else begin
            r_next.ls = LK_RX;
          end
        end
        LK_TX: begin
          if (r_reg.bit_cnt == 4'd8) begin
            r_next.sda_oe = 1'b0;
            r_next.ls = LK_TX_ACK;
          end else begin
            r_next.sda_oe = !r_reg.tx[47];
            r_next.tx = {r_reg.tx[46:0], 1'b1};
            r_next.bit_cnt = r_reg.bit_cnt + 4'd1;
          end
        end
        LK_TX_ACK: begin
          // Past six bytes the buffer shifts out ones
          r_next.ls = LK_TX;
          r_next.sda_oe = !r_reg.tx[47];
          r_next.tx = {r_reg.tx[46:0], 1'b1};
          r_next.bit_cnt = 4'd1;
        end
        default: begin
        end
      endcase
    end

    if (start_cond) begin
      r_next.ls = LK_RX;
      r_next.is_hdr = 1'b1;
      r_next.gcall = 1'b0;
      r_next.bit_cnt = 4'd0;
      r_next.sda_oe = 1'b0;
    end else if (stop_cond) begin
      r_next.ls = LK_IDLE;
      r_next.sda_oe = 1'b0;
    end
  end

  // ***************************************************
  // Registers
  // ***************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.s_scl <= 3'h7;
      r_reg.s_sda <= 3'h7;
      r_reg.scl_f <= 1'b1;
      r_reg.sda_f <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Only data is driven; clock is never held
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = r_reg.sda_oe;
  assign heater_on = r_reg.heater;
  assign heater_power = r_reg.pwr;
  assign busy = (r_reg.es != EN_IDLE);
  assign meas_done = r_reg.done;

endmodule // hts_sensor_dev

`default_nettype wire

/* File: rtl/hts_host_ctrl.sv */
/*
 * Controller end: issues a write of one command byte or a read of
 * up to six bytes, generating the link clock from sys_clk.
 * Assumes a user that pulses go only while busy is low.
 */
`timescale 1ns/1ns
`default_nettype none

module hts_host_ctrl
  import hts_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  i2c_link_if.host link,
  input wire logic go,
  input wire logic rd,
  input wire logic [6:0] addr,
  input wire logic [7:0] cmd,
  input wire logic [2:0] rd_len,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [47:0] rd_data,
  output logic crc_ok
);

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    host_st_t st;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [2:0] len;
    logic [2:0] left;
    logic hdr;
    logic rd;
    logic scl_oe;
    logic sda_oe;
    logic [2:0] s_sda;
    logic sda_f;
    logic busy;
    logic done;
    logic nack;
    logic [47:0] data;
    logic crc_ok;
  } host_state_t;

  host_state_t r_reg;
  host_state_t r_next;
  logic tick;
  logic tx;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.s_sda = {r_reg.s_sda[1:0], link.sda};
    if (r_reg.s_sda[1] == r_reg.s_sda[2]) begin
      r_next.sda_f = r_reg.s_sda[2];
    end
    tick = (r_reg.div == 8'(SCL_QTR_CYC - 1));
    tx = r_reg.hdr || !r_reg.rd;
    r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;
    if (r_reg.st == HS_IDLE) begin
      r_next.div = 8'h00;
    end

    case (r_reg.st)
      HS_IDLE: begin
        if (go) begin
          // Header is address then direction bit
          r_next.st = HS_START;
          r_next.q = 2'd0;
          r_next.sh = {addr, rd};
          r_next.cmd = cmd;
          r_next.rd = rd;
          r_next.len = rd_len;
          r_next.left = rd_len;
          r_next.hdr = 1'b1;
          r_next.nack = 1'b0;
          r_next.busy = 1'b1;
          r_next.data = '0;
        end
      end
      HS_START: begin
        if (tick) begin
          r_next.q = r_reg.q + 2'd1;
          case (r_reg.q)
            2'd0: begin
              r_next.scl_oe = 1'b0;
              r_next.sda_oe = 1'b0;
            end
            2'd1: r_next.sda_oe = 1'b1;
            2'd2: r_next.scl_oe = 1'b1;
            default: begin
              r_next.st = HS_BIT;
              r_next.bitn = 4'd0;
            end
          endcase
        end
      end
      HS_BIT: begin
        if (tick) begin
          r_next.q = r_reg.q + 2'd1;
          case (r_reg.q)
            2'd0: begin
              if (r_reg.bitn < 4'd8) begin
                r_next.sda_oe = tx && !r_reg.sh[7];
              end else begin
                // Last read byte is answered with NACK
                r_next.sda_oe = !tx && (r_reg.left != 3'd1);
              end
            end
            2'd1: r_next.scl_oe = 1'b0;
            2'd2: begin
              if (r_reg.bitn < 4'd8 && !tx) begin
                r_next.data = {r_reg.data[46:0], r_reg.sda_f};
              end
              if (r_reg.bitn == 4'd8 && tx && r_reg.sda_f) begin
                r_next.nack = 1'b1;
              end
            end
            default: begin
              r_next.scl_oe = 1'b1;
              if (r_reg.bitn < 4'd8) begin
                r_next.sh = {r_reg.sh[6:0], 1'b0};
                r_next.bitn = r_reg.bitn + 4'd1;
              end else begin
                r_next.bitn = 4'd0;
                if (tx) begin
                  r_next.hdr = 1'b0;
                  r_next.sh = r_reg.cmd;
                  if (r_reg.nack || !r_reg.hdr ||
                      (r_reg.rd && r_reg.len == 3'd0)) begin
                    r_next.st = HS_STOP;
                  end
                end else begin
                  r_next.left = r_reg.left - 3'd1;
                  if (r_reg.left == 3'd1) begin
                    r_next.st = HS_STOP;
                  end
                end
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          r_next.q = r_reg.q + 2'd1;
          case (r_reg.q)
            2'd0: r_next.sda_oe = 1'b1;
            2'd1: r_next.scl_oe = 1'b0;
            2'd2: r_next.sda_oe = 1'b0;
            default: begin
              r_next.st = HS_IDLE;
              r_next.busy = 1'b0;
              r_next.done = 1'b1;
              // Word checks
              if (r_reg.len == 3'd6) begin
                r_next.crc_ok =
                  (crc8_word(r_reg.data[47:32]) == r_reg.data[31:24]) &&
                  (crc8_word(r_reg.data[23:8]) == r_reg.data[7:0]);
              end else begin
                r_next.crc_ok =
                  (crc8_word(r_reg.data[23:8]) == r_reg.data[7:0]);
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.s_sda <= 3'h7;
      r_reg.sda_f <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = r_reg.scl_oe;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = r_reg.sda_oe;
  assign busy = r_reg.busy;
  assign done = r_reg.done;
  assign nack = r_reg.nack;
  assign rd_data = r_reg.data;
  assign crc_ok = r_reg.crc_ok;

endmodule // hts_host_ctrl

`default_nettype wire

/* File: tb/hts_props.sv */
/*
 * Checker for the sensor and controller pair on the two-wire link.
 * Assumes sys_clk and sys_rst are shared by both ends.
 */
`timescale 1ns/1ns
`default_nettype none

module hts_props #(
  parameter int HEAT_MAX = 20408
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic host_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic heater_on,
  input wire logic [1:0] heater_power,
  input wire logic busy,
  input wire logic meas_done
);
  // ***************************************************
  // Properties
  // ***************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  int heat_cnt;
  // Counter keeps the heater bound cheap to unroll
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !heater_on) heat_cnt <= 0;
    else heat_cnt <= heat_cnt + 1;
  end
  a_no_clk_stretch: assert property (!scl |-> host_scl_oe)
    else $error("clock held low by the sensor");
  a_drive_scl_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("sensor data changed with clock high");
  a_heat_busy: assert property (heater_on |-> busy && heater_power != 2'h0)
    else $error("heater on while idle");
  a_heat_power_off: assert property (!heater_on |-> heater_power == 2'h0)
    else $error("power level set with heater off");
  a_done_one_cycle: assert property (meas_done |=> !meas_done)
    else $error("result pulse too long");
  a_done_heat_off: assert property (
    meas_done |-> ##[0:2] (!heater_on && !busy))
    else $error("result ready with heater on");
  a_heat_limit: assert property (heat_cnt <= HEAT_MAX)
    else $error("heater on too long");
  a_reset_quiet: assert property (
    $fell(sys_rst) |-> !heater_on && !busy && !dev_sda_oe)
    else $error("activity right after reset");
endmodule // hts_props

`default_nettype wire

/* File: tb/tb.sv */
/*
 * Bench joining the controller and sensor through the link.
 * Assumes short counts; sensor inputs are held steady.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
  import hts_pkg::*;
  // ***************************************************
  // Setup
  // ***************************************************
  localparam logic [31:0] SER = 32'h5A5AC3C3; // Arbitrary serial
  localparam logic [15:0] TV = 16'hBEEF;
  localparam logic [15:0] HV = 16'h1234;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic go = 1'b0;
  logic rd = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] cmd = 8'h00;
  logic [2:0] rd_len = 3'h0;
  logic [15:0] temp_v = TV;
  logic [15:0] hum_v = HV;
  logic busy, done, nack, crc_ok, heater_on, dev_busy, meas_done;
  logic [1:0] heater_power;
  logic [47:0] rd_data;
  int fail_count = 0;
  int total_checks = 0;
  i2c_link_if lk();
  always #4 sys_clk = ~sys_clk;

  hts_sensor_dev #(.MEAS_HIGH_CNT(400), .RESET_CNT(100),
    .HEAT_LONG_CNT(20000), .HEAT_SHORT_CNT(6000),
    .SERIAL_NUM(SER)) u_hts_sensor_dev (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(lk), .temp_in(temp_v),
    .hum_in(hum_v), .heater_on(heater_on), .heater_power(heater_power),
    .busy(dev_busy), .meas_done(meas_done));
  hts_host_ctrl u_hts_host_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .link(lk), .go(go), .rd(rd), .addr(addr), .cmd(cmd),
    .rd_len(rd_len), .busy(busy), .done(done), .nack(nack),
    .rd_data(rd_data), .crc_ok(crc_ok));
  hts_props #(.HEAT_MAX(20408)) u_hts_props (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .scl(lk.scl), .host_scl_oe(lk.host_scl_oe),
    .dev_sda_oe(lk.dev_sda_oe), .heater_on(heater_on),
    .heater_power(heater_power), .busy(dev_busy),
    .meas_done(meas_done));

  // ***************************************************
  // Tasks
  // ***************************************************
  function automatic logic [7:0] calc_crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  task automatic chk(input string nm, input logic [47:0] seen,
                     input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One whole frame; the go pulse is lowered an edge later
  task automatic xfer(input logic r, input logic [6:0] a,
                      input logic [7:0] c, input logic [2:0] n);
    int k;
    k = 0;
    rd <= r;
    addr <= a;
    cmd <= c;
    rd_len <= n;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    while (done !== 1'b1 && k < 30000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 30000) fail_count++;
    @(posedge sys_clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ***************************************************
  // Tests
  // ***************************************************
  initial begin
    int k;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    xfer(1'b1, TARGET_ADDR, 8'h00, 3'h0);
    chk("empty read", nack, 1'b1);
    xfer(1'b0, TARGET_ADDR, CMD_HEAT_SHORT_HI, 3'h0);
    chk("heat ack", nack, 1'b0);
    chk("heat on", heater_on, 1'b1);
    chk("heat power", heater_power, PWR_HI);
    xfer(1'b1, TARGET_ADDR, 8'h00, 3'h0);
    chk("busy read", nack, 1'b1);
    k = 0;
    while (meas_done !== 1'b1 && k < 8000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 8000) fail_count++;
    repeat (3) @(posedge sys_clk);
    chk("heat off", heater_on, 1'b0);
    xfer(1'b1, TARGET_ADDR, 8'h00, 3'h6);
    chk("result ack", nack, 1'b0);
    chk("result", rd_data, {TV, calc_crc(TV), HV, calc_crc(HV)});
    chk("result crc", crc_ok, 1'b1);
    xfer(1'b1, TARGET_ADDR, 8'h00, 3'h0);
    chk("reread", nack, 1'b1);
    xfer(1'b0, TARGET_ADDR, CMD_SERIAL, 3'h0);
    xfer(1'b1, TARGET_ADDR, 8'h00, 3'h3);
    chk("serial", rd_data[23:0], {SER[31:16], calc_crc(SER[31:16])});
    xfer(1'b0, TARGET_ADDR, CMD_HEAT_LONG_LO, 3'h0);
    chk("long power", heater_power, PWR_LO);
    xfer(1'b0, TARGET_ADDR, CMD_SOFT_RESET, 3'h0);
    chk("soft ack", nack, 1'b0);
    chk("abort heat", heater_on, 1'b0);
    xfer(1'b0, TARGET_ADDR, CMD_SERIAL, 3'h0);
    xfer(1'b0, GEN_CALL_ADDR, GEN_RESET_BYTE, 3'h0);
    chk("gen ack", nack, 1'b0);
    xfer(1'b1, TARGET_ADDR, 8'h00, 3'h0);
    chk("gen cleared", nack, 1'b1);
    tally_and_finish();
  end

  // Frames above total about 85k cycles
  initial begin
    #780_000;
    fail_count++;
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire
